/* File: logic/spr_serial_port.sv */
// Purpose: Converter serial port with a data output shared with the ready flag
// Assumes: Master clock 20 MHz; serial clock is a separate domain, idle high
// Notes: Frame is one command byte (bit 6 = read) then data; continuous read has no command
// How it works
// (R1) Falling serial clock edges are active and data changes just after them.
// (R2) The host leaves 3, 12 or 24 master clocks between transfers per power mode.
// (R3) A new result arriving while ready is low first forces ready high for 6, 25 or 50 us.
// (R4) The host holds sync low for at least 3, 12 or 24 master clocks per power mode.
// (R5) Ready goes high again once the host has read the result.
// (R6) In single and continuous conversion the same result may be read again.
// (R7) In continuous read each result is shifted out only once.
// (R8) With the hold bit clear the pin turns to ready after the last rising clock edge.
// (R9) With the hold bit set the pin keeps the last data bit until chip select rises.
// (R10) Ready rises no sooner than 110 ns with delay extend set, 10 ns without.
// (R11) The host frames each transfer with chip select low.
`timescale 1ns/1ps
`default_nettype none
module spr_serial_port (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic DIN_IN,
  output logic DOUT_RDY_OUT,
  output logic DOUT_RDY_OE_OUT,
  input wire logic SYNC_N_IN,
  input wire logic [1:0] POWER_MODE_IN,
  input wire logic CONT_READ_IN,
  input wire logic CS_HOLD_IN,
  input wire logic READY_DELAY_EXTEND_IN,
  input wire logic CONV_DONE_IN,
  input wire logic [23:0] CONV_DATA_IN,
  output logic RDY_N_OUT,
  output logic READ_DONE_OUT,
  output logic [7:0] WR_BYTE_OUT,
  output logic WR_VALID_OUT,
  output logic SYNC_OUT,
  output logic GAP_ERR_OUT
);
  spr_pkg::spr_cfg_t cfg;
  spr_pkg::spr_main_st_t s_ff;
  spr_pkg::spr_main_st_t nxt_s;
  logic rd_tgl;
  logic wr_tgl;
  logic [7:0] link_byte;
  logic rd_e;
  logic wr_e;
  logic cs_fall;
  logic sy_rise;
  logic conv;
  logic [4:0] min_cyc;
  logic [9:0] plen_ff;

  function automatic logic [4:0] min_mclk(input spr_pkg::spr_pm_t pm);
    unique case (pm)
      spr_pkg::PM_FULL: min_mclk = spr_pkg::MIN_MCLK_FULL;
      spr_pkg::PM_MID: min_mclk = spr_pkg::MIN_MCLK_MID;
      default: min_mclk = spr_pkg::MIN_MCLK_LOW;
    endcase
  endfunction

  function automatic logic [9:0] pulse_cyc(input spr_pkg::spr_pm_t pm);
    unique case (pm)
      spr_pkg::PM_FULL: pulse_cyc = spr_pkg::PULSE_FULL_CYC;
      spr_pkg::PM_MID: pulse_cyc = spr_pkg::PULSE_MID_CYC;
      default: pulse_cyc = spr_pkg::PULSE_LOW_CYC;
    endcase
  endfunction

  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == spr_pkg::CNT_SAT) ? v : v + 5'h01;
  endfunction

  // Mode code 3 is not a legal power mode and is treated as low power
  assign cfg = '{pm: spr_pkg::spr_pm_t'(POWER_MODE_IN),
                 cont_read: CONT_READ_IN,
                 cs_hold: CS_HOLD_IN,
                 dly_ext: READY_DELAY_EXTEND_IN};

  // Link side runs on the serial clock; only toggles and a held byte come back
  spr_link u_link (
    .sclk_in(SCLK_IN),
    .cs_n_in(CS_N_IN),
    .rst_in(SYS_RST_IN),
    .din_in(DIN_IN),
    .cfg_in(cfg),
    .allow_in(s_ff.allow),
    .rdy_n_in(s_ff.rdy_n),
    .data_in(s_ff.data),
    .dout_out(DOUT_RDY_OUT),
    .dout_oe_out(DOUT_RDY_OE_OUT),
    .rd_tgl_out(rd_tgl),
    .wr_tgl_out(wr_tgl),
    .wr_byte_out(link_byte)
  );

  always_comb begin
    nxt_s = s_ff;
    conv = CONV_DONE_IN;
    min_cyc = min_mclk(cfg.pm);
    // Stage 0 of each chain feeds stage 1 only; edges are taken from stages 1 and 2
    // Toggles rather than pulses cross, so a short serial frame cannot be missed
    nxt_s.rd_s = {s_ff.rd_s[1:0], rd_tgl};
    nxt_s.wr_s = {s_ff.wr_s[1:0], wr_tgl};
    nxt_s.cs_s = {s_ff.cs_s[1:0], CS_N_IN};
    nxt_s.sy_s = {s_ff.sy_s[1:0], SYNC_N_IN};
    rd_e = s_ff.rd_s[2] ^ s_ff.rd_s[1];
    wr_e = s_ff.wr_s[2] ^ s_ff.wr_s[1];
    cs_fall = s_ff.cs_s[2] && !s_ff.cs_s[1];
    sy_rise = !s_ff.sy_s[2] && s_ff.sy_s[1];
    nxt_s.rd_evt = rd_e;
    nxt_s.wr_vld = wr_e;
    if (wr_e) begin
      nxt_s.wr_byte = link_byte;
    end
    // A new result is always kept; the ready flag tells the host when it is safe
    if (conv) begin
      nxt_s.data = CONV_DATA_IN;
    end
    unique case (s_ff.st)
      spr_pkg::RS_IDLE: begin
        if (conv) begin
          nxt_s.st = spr_pkg::RS_AVAIL;
        end
      end
      spr_pkg::RS_AVAIL: begin
        // Result and read in one cycle: the new result wins and must be flagged afresh
        if (conv) begin
          nxt_s.st = spr_pkg::RS_PULSE; // R3
          nxt_s.tmr = pulse_cyc(cfg.pm) - 10'h001;
        end else if (rd_e) begin
          nxt_s.st = spr_pkg::RS_DELAY; // R5
          nxt_s.tmr = (cfg.dly_ext ? spr_pkg::DLY_LONG_CYC
                                   : spr_pkg::DLY_SHORT_CYC) - 10'h001; // R10
        end
      end
      spr_pkg::RS_PULSE: begin
        if (s_ff.tmr == '0) begin
          nxt_s.st = spr_pkg::RS_AVAIL; // R3
        end else begin
          nxt_s.tmr = s_ff.tmr - 10'h001;
        end
      end
      spr_pkg::RS_DELAY: begin
        if (conv) begin
          nxt_s.pend = 1'b1;
        end
        if (s_ff.tmr == '0) begin
          // Ready is still low here, so a waiting result needs the high pulse
          nxt_s.st = (s_ff.pend || conv) ? spr_pkg::RS_PULSE : spr_pkg::RS_IDLE; // R3
          nxt_s.tmr = pulse_cyc(cfg.pm) - 10'h001;
          nxt_s.pend = 1'b0;
        end else begin
          nxt_s.tmr = s_ff.tmr - 10'h001;
        end
      end
    endcase
    nxt_s.rdy_n = !(nxt_s.st == spr_pkg::RS_AVAIL || nxt_s.st == spr_pkg::RS_DELAY);
    nxt_s.allow = !cfg.cont_read || nxt_s.st == spr_pkg::RS_AVAIL; // R7
    // Host spacing check, measured on the synchronised chip select
    nxt_s.gap_cnt = s_ff.cs_s[1] ? sat_inc(s_ff.gap_cnt) : 5'h00;
    nxt_s.gap_err = cs_fall && s_ff.gap_cnt < min_cyc; // R2
    // Sync is accepted only when the low level lasted long enough
    nxt_s.sy_cnt = s_ff.sy_s[1] ? 5'h00 : sat_inc(s_ff.sy_cnt);
    nxt_s.sync_pls = sy_rise && s_ff.sy_cnt >= min_cyc; // R4
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      s_ff <= spr_pkg::MAIN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign RDY_N_OUT = s_ff.rdy_n;
  assign READ_DONE_OUT = s_ff.rd_evt;
  assign WR_BYTE_OUT = s_ff.wr_byte;
  assign WR_VALID_OUT = s_ff.wr_vld;
  assign SYNC_OUT = s_ff.sync_pls;
  assign GAP_ERR_OUT = s_ff.gap_err;

  // Helper for the pulse length check
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      plen_ff <= '0;
    end else begin
      plen_ff <= (s_ff.st == spr_pkg::RS_PULSE) ? plen_ff + 10'h001 : 10'h000;
    end
  end

  // Checks run on the master clock and stay quiet while reset is high
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  a_pulse_enter: assert property ( // R3
    (s_ff.st == spr_pkg::RS_AVAIL && conv) |=> (s_ff.st == spr_pkg::RS_PULSE && s_ff.rdy_n))
    else $error("ready not pulsed high on result while low");

  a_pulse_length: assert property ( // R3
    (s_ff.st == spr_pkg::RS_PULSE && s_ff.tmr == '0)
      |-> (plen_ff == pulse_cyc(cfg.pm) - 10'h001))
    else $error("ready pulse length wrong");

  a_delay_long: assert property ( // R10
    (rd_e && s_ff.st == spr_pkg::RS_AVAIL && !conv && cfg.dly_ext)
      |=> (!s_ff.rdy_n)[*3] ##1 s_ff.rdy_n)
    else $error("extended ready delay wrong");

  a_delay_short: assert property ( // R10
    (rd_e && s_ff.st == spr_pkg::RS_AVAIL && !conv && !cfg.dly_ext)
      |=> !s_ff.rdy_n ##1 s_ff.rdy_n)
    else $error("short ready delay wrong");

  a_ready_back: assert property ( // R5
    (rd_e && s_ff.st == spr_pkg::RS_AVAIL) |-> ##[1:4] s_ff.rdy_n)
    else $error("ready not raised after read");

  a_read_once: assert property ( // R7
    (rd_e && s_ff.st == spr_pkg::RS_AVAIL && !conv && cfg.cont_read) |=> !s_ff.allow)
    else $error("continuous read allowed twice");

  a_reread_ok: assert property ( // R6
    (!cfg.cont_read) |=> s_ff.allow)
    else $error("reread blocked outside continuous read");

  a_sync_width: assert property ( // R4
    SYNC_OUT |-> ($past(s_ff.sy_cnt) >= $past(min_cyc) && $past(sy_rise)))
    else $error("sync accepted too short");

  a_sync_reject: assert property ( // R4
    (sy_rise && s_ff.sy_cnt < min_cyc) |=> !SYNC_OUT)
    else $error("short sync not rejected");

  a_gap_flag: assert property ( // R2
    (cs_fall && s_ff.gap_cnt < min_cyc) |=> GAP_ERR_OUT)
    else $error("short transfer gap not flagged");

  a_pin_frame: assert property ( // R11
    DOUT_RDY_OE_OUT == !CS_N_IN)
    else $error("output enable outside frame");

  // Spacing flags are one-cycle pulses; a legal gap must stay silent
  a_gap_quiet: assert property ( // R2
    (cs_fall && s_ff.gap_cnt >= min_cyc) |=> !GAP_ERR_OUT)
    else $error("legal transfer gap flagged");

  a_gap_single: assert property ( // R2
    GAP_ERR_OUT |=> !GAP_ERR_OUT)
    else $error("gap flag longer than one cycle");

  // Ready sequencing around the high pulse and the post-read delay
  a_pulse_exit: assert property ( // R3
    (s_ff.st == spr_pkg::RS_PULSE && s_ff.tmr == '0) |=> !s_ff.rdy_n)
    else $error("ready not low after high pulse");

  a_pend_pulse: assert property ( // R3
    (s_ff.st == spr_pkg::RS_DELAY && conv) |-> ##[1:4] (s_ff.st == spr_pkg::RS_PULSE))
    else $error("result during read delay not flagged");

  a_idle_ready: assert property ( // R5
    (s_ff.st == spr_pkg::RS_DELAY && s_ff.tmr == '0 && !s_ff.pend && !conv)
      |=> (s_ff.st == spr_pkg::RS_IDLE && s_ff.rdy_n))
    else $error("ready not high after read delay");

  // Handover of link events into this domain
  a_read_strobe: assert property ( // R5
    rd_e |=> READ_DONE_OUT)
    else $error("read completion not reported");

  a_read_single: assert property ( // R5
    READ_DONE_OUT |=> !READ_DONE_OUT)
    else $error("read completion longer than one cycle");

  a_write_seen: assert property ( // R11
    wr_e |=> (WR_VALID_OUT && WR_BYTE_OUT == $past(link_byte)))
    else $error("written byte not handed over");

  // Stored result only moves on a new conversion, which is what makes a reread safe
  a_result_kept: assert property ( // R6
    conv |=> (s_ff.data == $past(CONV_DATA_IN)))
    else $error("new result not stored");

  a_data_still: assert property ( // R6
    !conv |=> $stable(s_ff.data))
    else $error("stored result changed without a new one");

  a_sync_edge: assert property ( // R4
    !sy_rise |=> !SYNC_OUT)
    else $error("sync accepted without a rising edge");

  a_sync_single: assert property ( // R4
    SYNC_OUT |=> !SYNC_OUT)
    else $error("sync pulse longer than one cycle");

  c_pulse_done: cover property (s_ff.st == spr_pkg::RS_PULSE && s_ff.tmr == '0);
  c_read_taken: cover property (rd_e && s_ff.st == spr_pkg::RS_AVAIL);
  c_write_byte: cover property (WR_VALID_OUT);
  c_sync_taken: cover property (SYNC_OUT);
  c_cont_blocked: cover property (cfg.cont_read && !s_ff.allow);
endmodule // spr_serial_port
`default_nettype wire

/* File: logic/spr_pkg.sv */
// Purpose: Shared constants and types for the serial port with ready signalling
// Assumes: Master clock of 20 MHz on the converter side
// Notes: Serial clock side types live here too
`default_nettype none
package spr_pkg;
  localparam int MCLK_MHZ = 20;
  localparam int DATA_W = 24;
  localparam int CMD_W = 8;
  localparam int RD_FLAG_BIT = 6;
  localparam logic [5:0] CMD_LOAD_FALL = 6'h08;
  localparam logic [5:0] CMD_LAST_RISE = 6'h07;
  localparam logic [5:0] CONT_END_RISE = 6'h17;
  localparam logic [5:0] CMD_END_RISE = 6'h1f;
  // Least host spacing and sync width, in master clock periods
  localparam logic [4:0] MIN_MCLK_FULL = 5'h03;
  localparam logic [4:0] MIN_MCLK_MID = 5'h0c;
  localparam logic [4:0] MIN_MCLK_LOW = 5'h18;
  localparam logic [4:0] CNT_SAT = 5'h1f;
  localparam int PULSE_FULL_US = 6;
  localparam int PULSE_MID_US = 25;
  localparam int PULSE_LOW_US = 50;
  localparam logic [9:0] PULSE_FULL_CYC = 10'(PULSE_FULL_US * MCLK_MHZ);
  localparam logic [9:0] PULSE_MID_CYC = 10'(PULSE_MID_US * MCLK_MHZ);
  localparam logic [9:0] PULSE_LOW_CYC = 10'(PULSE_LOW_US * MCLK_MHZ);
  localparam int DLY_SHORT_NS = 10;
  localparam int DLY_LONG_NS = 110;
  localparam logic [9:0] DLY_SHORT_CYC = 10'((DLY_SHORT_NS * MCLK_MHZ + 999) / 1000);
  localparam logic [9:0] DLY_LONG_CYC = 10'((DLY_LONG_NS * MCLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {PM_FULL, PM_MID, PM_LOW} spr_pm_t;
  typedef enum logic [1:0] {RS_IDLE, RS_AVAIL, RS_PULSE, RS_DELAY} spr_rdy_st_t;

  typedef struct packed {
    spr_pm_t pm;
    logic cont_read;
    logic cs_hold;
    logic dly_ext;
  } spr_cfg_t;

  typedef struct packed {
    spr_rdy_st_t st;
    logic [9:0] tmr;
    logic pend;
    logic rdy_n;
    logic allow;
    logic [DATA_W-1:0] data;
    logic [2:0] rd_s;
    logic [2:0] wr_s;
    logic [2:0] cs_s;
    logic [2:0] sy_s;
    logic [4:0] gap_cnt;
    logic [4:0] sy_cnt;
    logic rd_evt;
    logic wr_vld;
    logic [7:0] wr_byte;
    logic sync_pls;
    logic gap_err;
  } spr_main_st_t;

  localparam spr_main_st_t MAIN_RST = '{st: RS_IDLE, rdy_n: 1'b1, cs_s: 3'h7, sy_s: 3'h7,
                                         gap_cnt: CNT_SAT, default: '0};

  typedef struct packed {
    logic [5:0] fcnt;
    logic [DATA_W-1:0] sh;
    logic on;
  } spr_lneg_t;

  typedef struct packed {
    logic [5:0] rcnt;
    logic [7:0] cmd;
    logic is_rd;
    logic ended;
  } spr_lpos_t;

  typedef struct packed {
    logic rd_tgl;
    logic wr_tgl;
    logic [7:0] wr_byte;
  } spr_lpers_t;
endpackage
`default_nettype wire

/* File: logic/spr_link.sv */
// Purpose: Serial clock side of the port: command capture, data shift-out, pin mux
// Assumes: Configuration levels stay still while a frame is open
// Notes: Frame state is cleared by chip select going high, so no edge after a frame is needed
`timescale 1ns/1ps
`default_nettype none
module spr_link (
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic rst_in,
  input wire logic din_in,
  input wire spr_pkg::spr_cfg_t cfg_in,
  input wire logic allow_in,
  input wire logic rdy_n_in,
  input wire logic [spr_pkg::DATA_W-1:0] data_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic rd_tgl_out,
  output logic wr_tgl_out,
  output logic [7:0] wr_byte_out
);
  spr_pkg::spr_lneg_t n_ff, nxt_n;
  spr_pkg::spr_lpos_t p_ff, nxt_p;
  spr_pkg::spr_lpers_t k_ff, nxt_k;
  logic [7:0] in_byte;
  logic [5:0] end_rise;
  logic rd_end;

  // Falling edge drives data; the word is taken from a level that is held
  // still while ready is low outside the post-read delay, so no second sampling stage is needed
  always_comb begin
    nxt_n = n_ff;
    nxt_n.fcnt = n_ff.fcnt + 6'h01;
    nxt_n.sh = {n_ff.sh[spr_pkg::DATA_W-2:0], 1'b0}; // R1
    if (n_ff.fcnt == '0 && cfg_in.cont_read && allow_in) begin
      nxt_n.sh = data_in; // R7
      nxt_n.on = 1'b1;
    end else if (n_ff.fcnt == spr_pkg::CMD_LOAD_FALL && !cfg_in.cont_read && p_ff.is_rd) begin
      nxt_n.sh = data_in; // R6
      nxt_n.on = 1'b1;
    end
  end

  // System reset clears the frame state too, so the first frame after start-up is clean
  always_ff @(negedge sclk_in or posedge cs_n_in or posedge rst_in) begin
    if (cs_n_in || rst_in) begin
      n_ff <= '0; // R11
    end else begin
      n_ff <= nxt_n;
    end
  end

  always_comb begin
    in_byte = {p_ff.cmd[6:0], din_in};
    end_rise = cfg_in.cont_read ? spr_pkg::CONT_END_RISE : spr_pkg::CMD_END_RISE;
    rd_end = n_ff.on && p_ff.rcnt == end_rise;
    nxt_p = p_ff;
    nxt_p.rcnt = p_ff.rcnt + 6'h01;
    nxt_p.cmd = in_byte;
    if (p_ff.rcnt == spr_pkg::CMD_LAST_RISE && !cfg_in.cont_read) begin
      nxt_p.is_rd = in_byte[spr_pkg::RD_FLAG_BIT];
    end
    if (rd_end) begin
      nxt_p.ended = 1'b1; // R8
    end
    nxt_k = k_ff;
    if (rd_end) begin
      nxt_k.rd_tgl = !k_ff.rd_tgl; // R5
    end
    if (!cfg_in.cont_read && !p_ff.is_rd && p_ff.rcnt[2:0] == 3'h7
        && p_ff.rcnt > spr_pkg::CMD_LAST_RISE) begin
      nxt_k.wr_byte = in_byte;
      nxt_k.wr_tgl = !k_ff.wr_tgl;
    end
  end

  always_ff @(posedge sclk_in or posedge cs_n_in or posedge rst_in) begin
    if (cs_n_in || rst_in) begin
      p_ff <= '0;
    end else begin
      p_ff <= nxt_p;
    end
  end

  // Toggles outlive the frame, so they are cleared only by system reset
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      k_ff <= '0;
    end else begin
      k_ff <= nxt_k;
    end
  end

  assign dout_oe_out = !cs_n_in; // R11
  // Data until the read ends; then ready, unless the hold bit keeps the last bit
  assign dout_out = (n_ff.on && (!p_ff.ended || cfg_in.cs_hold)) ? n_ff.sh[spr_pkg::DATA_W-1]
                                                                 : rdy_n_in; // R9
  assign rd_tgl_out = k_ff.rd_tgl;
  assign wr_tgl_out = k_ff.wr_tgl;
  assign wr_byte_out = k_ff.wr_byte;
endmodule // spr_link
`default_nettype wire

/* File: bench/spr_host.sv */
// Purpose: Host controller model that frames transfers on the serial link
// Assumes: Serial clock idles high between frames and runs at an 80 ns period
// Notes: The caller picks the gap after each frame, so a short one can be provoked
`timescale 1ns/1ps
`default_nettype none
module spr_host (
  input wire logic dout_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end

  // Data is sampled just before each rising edge, the tail 640 ns after the last one
  task automatic xfer(input int n, input logic [31:0] tx, input int gap_ns,
                      output logic [31:0] rx, output logic tail);
    rx = '0;
    cs_n_out = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b0;
      din_out = tx[n-1-i];
      #40;
      rx = {rx[30:0], dout_in};
      sclk_out = 1'b1;
      #40;
    end
    #600;
    tail = dout_in;
    cs_n_out = 1'b1;
    // Released line shows the opposite level so a stale bit cannot pass
    din_out = ~din_out;
    #(gap_ns);
  endtask
endmodule // spr_host
`default_nettype wire

/* File: bench/spr_serial_port_test.sv */
// Purpose: Self-checking bench for the serial port with shared ready pin
// Assumes: Master clock 20 MHz, serial clock from the host model
// Notes: Results, written bytes and the hold and delay extend settings come from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module spr_serial_port_test;
  logic mclk, rst, sync_n, cont, hold, ext, done, rdy_prev, tail;
  logic [1:0] pm;
  logic [23:0] cdata, d;
  logic [31:0] seed, rx;
  wire logic sclk, cs_n, din, dout, oe, rdy_n, rd_done, wr_vld, sync_p, gap_err;
  wire logic [7:0] wr_byte;
  wire logic pin;
  int mismatches, checked, cyc, rd_cnt, wr_cnt, sy_cnt, ge_cnt, dly, rise_dly;
  int n, r0, s0;

  always #25 mclk = ~mclk;

  spr_serial_port i_spr_serial_port (.MCLK_IN(mclk), .SYS_RST_IN(rst), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .DIN_IN(din), .DOUT_RDY_OUT(dout), .DOUT_RDY_OE_OUT(oe),
    .SYNC_N_IN(sync_n), .POWER_MODE_IN(pm), .CONT_READ_IN(cont), .CS_HOLD_IN(hold),
    .READY_DELAY_EXTEND_IN(ext), .CONV_DONE_IN(done), .CONV_DATA_IN(cdata),
    .RDY_N_OUT(rdy_n), .READ_DONE_OUT(rd_done), .WR_BYTE_OUT(wr_byte),
    .WR_VALID_OUT(wr_vld), .SYNC_OUT(sync_p), .GAP_ERR_OUT(gap_err));

  // Undriven pin shows the inverse, so a value seen outside a frame cannot pass
  assign pin = oe ? dout : ~dout;

  spr_host i_spr_host (.dout_in(pin), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic int min_cyc(input logic [1:0] m);
    return m == 2'h0 ? 3 : (m == 2'h1 ? 12 : 24);
  endfunction

  function automatic int pulse_cyc(input logic [1:0] m);
    return (m == 2'h0 ? 6 : (m == 2'h1 ? 25 : 50)) * 20;
  endfunction

  task chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pulse counters and the delay from read completion to ready rising
  always @(negedge mclk) begin
    cyc++;
    if (rd_done === 1'b1) begin
      rd_cnt++;
      dly = 0;
    end else begin
      dly++;
    end
    if (rdy_prev === 1'b0 && rdy_n === 1'b1) begin
      rise_dly = dly;
    end
    rdy_prev = rdy_n;
    wr_cnt += int'(wr_vld === 1'b1);
    sy_cnt += int'(sync_p === 1'b1);
    ge_cnt += int'(gap_err === 1'b1);
    if (cyc > 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task conv(input logic [23:0] v);
    @(negedge mclk);
    done = 1'b1;
    cdata = v;
    @(negedge mclk);
    done = 1'b0;
  endtask

  task rd(input logic [23:0] v, input bit fresh);
    r0 = rd_cnt;
    rise_dly = -1;
    i_spr_host.xfer(cont ? 24 : 32, 32'h4000_0000, 1500, rx, tail);
    chk(rx[23:0] === v, "read data");
    chk(tail === (hold ? v[0] : 1'b1), "pin level after read");
    chk(rd_cnt == r0 + 1 && rdy_n === 1'b1, "ready after read");
    if (fresh) begin
      chk(rise_dly >= (ext ? 3 : 1) && rise_dly <= 8, "ready delay");
    end
  endtask

  initial begin
    mclk = 1'b0;
    // Reset rises just after time zero so its edge is not lost at start-up
    rst = 1'b0;
    sync_n = 1'b1;
    {cont, hold, ext, done, pm, cdata} = '0;
    seed = 32'h8d85;
    rdy_prev = 1'b1;
    #1;
    rst = 1'b1;
    repeat (6) @(negedge mclk);
    chk(rdy_n === 1'b1 && oe === 1'b0, "reset state");
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    // Code 3 is expected to behave as low power
    for (int m = 0; m < 4; m++) begin
      @(negedge mclk);
      pm = 2'(m);
      seed = xs(seed);
      // Hold follows mode bit 1 and delay extend mode bit 0, each flipped by seed bit 0
      {hold, ext} = 2'(m) ^ {2{seed[0]}};
      conv(seed[31:8]);
      chk(rdy_n === 1'b0, "ready low on result");
      seed = xs(seed);
      d = seed[23:0];
      conv(d);
      n = 0;
      while (rdy_n === 1'b1 && n < 2000) begin
        @(negedge mclk);
        n++;
      end
      chk(n == pulse_cyc(pm), "ready high pulse");
      rd(d, 1'b1);
      rd(d, 1'b0);
      @(negedge mclk);
      sync_n = 1'b0;
      repeat (min_cyc(pm) + 1) @(negedge mclk);
      sync_n = 1'b1;
      s0 = sy_cnt;
      repeat (8) @(negedge mclk);
      chk(sy_cnt == s0 + 1, "sync pulse");
      sync_n = 1'b0;
      repeat (min_cyc(pm) - 1) @(negedge mclk);
      sync_n = 1'b1;
      s0 = sy_cnt;
      repeat (8) @(negedge mclk);
      chk(sy_cnt == s0, "short sync rejected");
    end
    @(negedge mclk);
    pm = 2'h0;
    seed = xs(seed);
    r0 = wr_cnt;
    i_spr_host.xfer(16, {24'h0, seed[7:0]}, 1500, rx, tail);
    chk(wr_cnt == r0 + 1 && wr_byte === seed[7:0], "written byte");
    // Third frame starts one master clock after the second ends
    i_spr_host.xfer(16, {24'h0, seed[15:8]}, 50, rx, tail);
    i_spr_host.xfer(16, {24'h0, seed[15:8]}, 1500, rx, tail);
    chk(ge_cnt == 1, "short gap flagged");
    @(negedge mclk);
    cont = 1'b1;
    hold = 1'b0;
    seed = xs(seed);
    d = seed[23:0];
    conv(d);
    rd(d, 1'b1);
    r0 = rd_cnt;
    i_spr_host.xfer(24, 32'h0, 1500, rx, tail);
    chk(rx[23:0] === 24'hffffff && rd_cnt == r0, "second continuous read");
    stop_test();
  end
endmodule // spr_serial_port_test
`default_nettype wire
